// file: bench/umcl_peer.sv
// Remote serial peer: idles its line high and sends one frame on request
`timescale 1ns/10ps
module umcl_peer #(
  parameter int BIT_CYC = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic send,
  input wire logic [7:0] data,
  output logic line
);
  // ---------------------------------------------------------------------------
  // Frame shifter
  // ---------------------------------------------------------------------------
  logic [9:0] frame;
  int bits_left;
  int cyc;

  // Start bit low, data LSB first, one stop bit high; idle level is high
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      frame <= 10'h3FF;
      bits_left <= 0;
      cyc <= 0;
      line <= 1'b1;
    end else if (send && bits_left == 0) begin
      frame <= {1'b1, data, 1'b0};
      bits_left <= 10;
      cyc <= 0;
    end else if (bits_left != 0) begin
      line <= frame[10 - bits_left];
      cyc <= (cyc == BIT_CYC - 1) ? 0 : cyc + 1;
      if (cyc == BIT_CYC - 1) begin
        bits_left <= bits_left - 1;
      end
    end else begin
      line <= 1'b1;
    end
  end
endmodule

// file: bench/umcl_top_test.sv
// Self-checking bench for the modem-control / line-status block
`timescale 1ns/10ps
module umcl_top_test;
  localparam logic [31:0] A0M = umcl_pkg::ADDR_MODEM_CONTROL_U0;
  localparam logic [31:0] A0L = umcl_pkg::ADDR_LINE_STATUS_U0;
  localparam logic [31:0] A1M = umcl_pkg::ADDR_MODEM_CONTROL_U1;
  localparam logic [31:0] A1L = umcl_pkg::ADDR_LINE_STATUS_U1;
  logic clk, arst_n, clk_en, bus_wr, bus_rd, send, peer_line;
  logic [31:0] bus_addr;
  logic [15:0] bus_wdata, bus_rdata;
  logic [1:0] serial_out_line, tx_raw_line, rx_line, rts_level, dtr_level, aux_output_one, aux_output_two;
  logic [1:0][1:0] char_size_field;
  logic [1:0][3:0] break_char_bits;
  logic [7:0] pdata;
  umcl_pkg::umcl_evt_s [1:0] evt;
  umcl_pkg::umcl_modem_s [1:0] modem_in, modem_status;
  umcl_pkg::umcl_evt_s e;
  int n_fail, n_checks, cycles;

  umcl_top DUT (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .serial_in_line({peer_line, 1'b1}),
    .serial_out_line(serial_out_line), .tx_raw_line(tx_raw_line), .rx_line(rx_line),
    .char_size_field(char_size_field), .evt(evt), .modem_in(modem_in), .modem_status(modem_status),
    .rts_level(rts_level), .dtr_level(dtr_level), .aux_output_one(aux_output_one),
    .aux_output_two(aux_output_two), .break_char_bits(break_char_bits));
  umcl_peer peer (.clk(clk), .arst_n(arst_n), .send(send), .data(pdata), .line(peer_line));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so it is sampled there
  task automatic rd(input logic [31:0] a, input logic [15:0] exp);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 chk(bus_rdata, exp);
  endtask

  // Pulses drop after one cycle; the queue-error level is kept as given
  task automatic pulse(input umcl_pkg::umcl_evt_s p);
    @(posedge clk);
    evt[1] <= p;
    @(posedge clk);
    evt[1] <= umcl_pkg::umcl_evt_s'({8'h00, p.rx_queue_err_left});
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial begin
    {arst_n, bus_wr, bus_rd, send, bus_addr, bus_wdata, pdata, char_size_field} = '0;
    clk_en = 1'b1;
    tx_raw_line = 2'b11;
    evt = '0;
    modem_in = {4'hA, 4'h6};
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    rd(A0M, 16'h0000);
    rd(A0L, 16'h0060);
    rd(A1M, 16'h0000);
    rd(A1L, 16'h0060);
    rd(32'h40020018, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      char_size_field <= {2'(3 - i), 2'(i)};
      settle();
      chk({8'h0, break_char_bits}, {4'(8 - i), 4'(5 + i)});
    end
    $display("reset and size test done");
    tx_raw_line <= 2'b00;
    wr(A0M, 16'hFFF5);
    rd(A0M, 16'h0015);
    #1 chk({14'h0, serial_out_line}, 16'h0001);
    chk({15'h0, rx_line[0]}, 16'h0000);
    chk({8'h0, modem_status}, 16'hA9);
    chk({14'h0, dtr_level}, 16'h0002);
    chk({14'h0, rts_level}, 16'h0003);
    chk({14'h0, aux_output_one}, 16'h0002);
    chk({14'h0, aux_output_two}, 16'h0003);
    wr(A0M, 16'h000A);
    settle();
    chk({8'h0, rts_level, aux_output_two, dtr_level, aux_output_one}, 16'h00AF);
    chk({8'h0, modem_status}, 16'hA6);
    wr(A0L, 16'h00FF);
    rd(A0L, 16'h0060);
    $display("modem control test done");
    for (int i = 0; i < 3; i++) begin
      e = '0;
      e.rx_parity_bad = (i == 0);
      e.rx_stop_bad = (i == 1);
      e.rx_break = (i == 2);
      pulse(e);
      rd(A1L, 16'h00E0 | (16'h0004 << i));
      rd(A1L, 16'h0060);
    end
    e = '0;
    e.rx_byte = 1'b1;
    pulse(e);
    pulse(e);
    rd(A1L, 16'h0063);
    rd(A1L, 16'h0061);
    e = '0;
    e.rx_read = 1'b1;
    pulse(e);
    rd(A1L, 16'h0060);
    e = '0;
    e.tx_hold_written = 1'b1;
    pulse(e);
    rd(A1L, 16'h0000);
    e = '0;
    e.tx_hold_loaded = 1'b1;
    pulse(e);
    rd(A1L, 16'h0020);
    e = '0;
    e.tx_shift_done = 1'b1;
    pulse(e);
    rd(A1L, 16'h0060);
    $display("status flag test done");
    e = '0;
    e.rx_parity_bad = 1'b1;
    e.rx_queue_err_left = 1'b1;
    pulse(e);
    rd(A1L, 16'h00E4);
    rd(A1L, 16'h00E0);
    pulse('0);
    rd(A1L, 16'h00E0);
    rd(A1L, 16'h0060);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= A1L;
    evt[1].rx_stop_bad <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    evt[1] <= '0;
    #1 chk(bus_rdata, 16'h0060);
    rd(A1L, 16'h00E8);
    $display("queue error and collision test done");
    clk_en <= 1'b0;
    wr(A1M, 16'h0010);
    @(posedge clk);
    clk_en <= 1'b1;
    rd(A1M, 16'h0000);
    $display("clock enable test done");
    @(posedge clk);
    send <= 1'b1;
    pdata <= 8'hA5;
    @(posedge clk);
    send <= 1'b0;
    for (int i = 0; i < 12 && rx_line[1] !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    #1 chk({15'h0, rx_line[1]}, 16'h0000);
    $display("line input test done");
    report_and_stop();
  end
endmodule

// file: logic/umcl_pkg.sv
// Package: register map, field positions, reset values and shared types of the modem-control / line-status block
package umcl_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [31:0] ADDR_MODEM_CONTROL_U0 = 32'h40020010;
  localparam logic [31:0] ADDR_LINE_STATUS_U0 = 32'h40020014;
  localparam logic [31:0] ADDR_MODEM_CONTROL_U1 = 32'h40020410;
  localparam logic [31:0] ADDR_LINE_STATUS_U1 = 32'h40020414;
  localparam logic [31:0] ADDR_UNIT_STRIDE = 32'h00000400;
  localparam int NUM_UNITS = 2;

  localparam logic [15:0] MODEM_CONTROL_RESET = 16'h0000;
  localparam logic [15:0] LINE_STATUS_RESET = 16'h0060;
  localparam logic [15:0] READ_UNMAPPED = 16'h0000;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int MC_DTR = 0;
  localparam int MC_RTS = 1;
  localparam int MC_AUX1 = 2;
  localparam int MC_AUX2 = 3;
  localparam int MC_LOOPBACK = 4;
  localparam int MC_WIDTH = 5;

  localparam int LS_RX_READY = 0;
  localparam int LS_OVERRUN = 1;
  localparam int LS_PARITY = 2;
  localparam int LS_FRAMING = 3;
  localparam int LS_BREAK = 4;
  localparam int LS_TX_HOLD_EMPTY = 5;
  localparam int LS_TX_ALL_EMPTY = 6;
  localparam int LS_RX_QUEUE_ERR = 7;
  localparam int LS_WIDTH = 8;

  // Character size codes 0..3 mean 5..8 data bits
  localparam logic [3:0] CHAR_BITS_BASE = 4'h5;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } umcl_bus_s;

  // Per-unit events reported by the transmitter and receiver around the block
  typedef struct packed {
    logic tx_hold_written;
    logic tx_hold_loaded;
    logic tx_shift_done;
    logic rx_byte;
    logic rx_read;
    logic rx_parity_bad;
    logic rx_stop_bad;
    logic rx_break;
    logic rx_queue_err_left;
  } umcl_evt_s;

  // Modem signals, logic levels as seen on the internal nets
  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } umcl_modem_s;

endpackage

// file: logic/umcl_top.sv
// Modem-control and line-status registers for two serial units
`timescale 1ns/10ps
module umcl_top (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [31:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [15:0] bus_rdata,
  input wire logic [1:0] serial_in_line,
  output logic [1:0] serial_out_line,
  input wire logic [1:0] tx_raw_line,
  output logic [1:0] rx_line,
  input wire logic [1:0][1:0] char_size_field,
  input wire umcl_pkg::umcl_evt_s [1:0] evt,
  input wire umcl_pkg::umcl_modem_s [1:0] modem_in,
  output umcl_pkg::umcl_modem_s [1:0] modem_status,
  output logic [1:0] rts_level,
  output logic [1:0] dtr_level,
  output logic [1:0] aux_output_one,
  output logic [1:0] aux_output_two,
  output logic [1:0][3:0] break_char_bits
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0][umcl_pkg::MC_WIDTH-1:0] modem_control;
    logic [1:0][umcl_pkg::LS_WIDTH-1:0] line_status;
    logic [1:0] sin_meta;
    logic [1:0] sin_sync;
    logic [1:0] sout;
    logic [1:0] rxl;
    umcl_pkg::umcl_modem_s [1:0] mst;
    logic [1:0] rts;
    logic [1:0] dtr;
    logic [1:0] aux1;
    logic [1:0] aux2;
    logic [1:0][3:0] brk_bits;
    logic [15:0] rdata;
  } umcl_state_s;

  umcl_state_s st;
  umcl_state_s next_st;

  localparam umcl_state_s ST_RESET = '{
    modem_control: {2{umcl_pkg::MODEM_CONTROL_RESET[umcl_pkg::MC_WIDTH-1:0]}},
    line_status: {2{umcl_pkg::LINE_STATUS_RESET[umcl_pkg::LS_WIDTH-1:0]}},
    sin_meta: 2'h3,
    sin_sync: 2'h3,
    sout: 2'h3,
    rxl: 2'h3,
    mst: '0,
    rts: 2'h3,
    dtr: 2'h3,
    aux1: 2'h3,
    aux2: 2'h3,
    brk_bits: {2{umcl_pkg::CHAR_BITS_BASE}},
    rdata: 16'h0000
  };

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  logic [1:0] hit_mc;
  logic [1:0] hit_ls;

  genvar gu;
  generate
    for (gu = 0; gu < umcl_pkg::NUM_UNITS; gu++) begin : g_dec
      assign hit_mc[gu] = bus_addr == umcl_pkg::ADDR_MODEM_CONTROL_U0 + 32'(gu) * umcl_pkg::ADDR_UNIT_STRIDE;
      assign hit_ls[gu] = bus_addr == umcl_pkg::ADDR_LINE_STATUS_U0 + 32'(gu) * umcl_pkg::ADDR_UNIT_STRIDE;
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [umcl_pkg::MC_WIDTH-1:0] mc;
    logic [umcl_pkg::LS_WIDTH-1:0] ls;
    logic ls_rd;
    logic loop;
    logic txe;
    mc = '0;
    ls = '0;
    ls_rd = 1'b0;
    loop = 1'b0;
    txe = 1'b0;
    next_st = st;
    next_st.sin_meta = serial_in_line;
    next_st.sin_sync = st.sin_meta;
    next_st.rdata = umcl_pkg::READ_UNMAPPED;
    for (int u = 0; u < umcl_pkg::NUM_UNITS; u++) begin
      mc = st.modem_control[u];
      ls = st.line_status[u];
      ls_rd = bus_rd && hit_ls[u];
      if (bus_wr && hit_mc[u]) begin
        mc = bus_wdata[umcl_pkg::MC_WIDTH-1:0];
      end
      if (bus_rd && hit_mc[u]) begin
        next_st.rdata = {11'h000, st.modem_control[u]};
      end
      if (ls_rd) begin
        next_st.rdata = {8'h00, st.line_status[u]};
      end
      // Sticky errors: a read clears them and loads queue error from the errors-left level, but a same-cycle event wins
      if (ls_rd) begin
        ls[umcl_pkg::LS_OVERRUN] = 1'b0;
        ls[umcl_pkg::LS_PARITY] = 1'b0;
        ls[umcl_pkg::LS_FRAMING] = 1'b0;
        ls[umcl_pkg::LS_BREAK] = 1'b0;
        ls[umcl_pkg::LS_RX_QUEUE_ERR] = evt[u].rx_queue_err_left;
      end
      if (evt[u].rx_break) ls[umcl_pkg::LS_BREAK] = 1'b1;
      if (evt[u].rx_stop_bad) ls[umcl_pkg::LS_FRAMING] = 1'b1;
      if (evt[u].rx_parity_bad) ls[umcl_pkg::LS_PARITY] = 1'b1;
      if (evt[u].rx_byte && st.line_status[u][umcl_pkg::LS_RX_READY] && !evt[u].rx_read) begin
        ls[umcl_pkg::LS_OVERRUN] = 1'b1;
      end
      if (evt[u].rx_parity_bad || evt[u].rx_stop_bad || evt[u].rx_break) begin
        ls[umcl_pkg::LS_RX_QUEUE_ERR] = 1'b1;
      end
      // Data ready ignores status reads; new data beats a simultaneous receive read
      if (evt[u].rx_read) ls[umcl_pkg::LS_RX_READY] = 1'b0;
      if (evt[u].rx_byte) ls[umcl_pkg::LS_RX_READY] = 1'b1;
      // Transmit side: holding empty clears on write, sets when shift reg takes it
      txe = ls[umcl_pkg::LS_TX_HOLD_EMPTY];
      if (evt[u].tx_hold_loaded) txe = 1'b1;
      if (evt[u].tx_hold_written) txe = 1'b0;
      ls[umcl_pkg::LS_TX_HOLD_EMPTY] = txe;
      if (evt[u].tx_hold_written) begin
        ls[umcl_pkg::LS_TX_ALL_EMPTY] = 1'b0;
      end else if (evt[u].tx_shift_done && txe) begin
        ls[umcl_pkg::LS_TX_ALL_EMPTY] = 1'b1;
      end
      next_st.modem_control[u] = mc;
      next_st.line_status[u] = ls;
      // DTR, RTS and aux outputs follow the stored control bits, inverted
      loop = st.modem_control[u][umcl_pkg::MC_LOOPBACK];
      next_st.dtr[u] = ~st.modem_control[u][umcl_pkg::MC_DTR];
      next_st.rts[u] = ~st.modem_control[u][umcl_pkg::MC_RTS];
      next_st.aux1[u] = ~st.modem_control[u][umcl_pkg::MC_AUX1];
      next_st.aux2[u] = ~st.modem_control[u][umcl_pkg::MC_AUX2];
      next_st.sout[u] = loop ? 1'b1 : tx_raw_line[u];
      next_st.rxl[u] = loop ? tx_raw_line[u] : st.sin_sync[u];
      if (loop) begin
        next_st.mst[u].cts = ~st.modem_control[u][umcl_pkg::MC_RTS];
        next_st.mst[u].dsr = ~st.modem_control[u][umcl_pkg::MC_DTR];
        next_st.mst[u].ri = ~st.modem_control[u][umcl_pkg::MC_AUX1];
        next_st.mst[u].dcd = ~st.modem_control[u][umcl_pkg::MC_AUX2];
      end else begin
        next_st.mst[u] = modem_in[u];
      end
      next_st.brk_bits[u] = umcl_pkg::CHAR_BITS_BASE + {2'b00, char_size_field[u]};
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= ST_RESET;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign bus_rdata = st.rdata;
  assign serial_out_line = st.sout;
  assign rx_line = st.rxl;
  assign modem_status = st.mst;
  assign rts_level = st.rts;
  assign dtr_level = st.dtr;
  assign aux_output_one = st.aux1;
  assign aux_output_two = st.aux2;
  assign break_char_bits = st.brk_bits;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  // Outputs lag the stored bits by one cycle, so most checks look one edge later
  a_loop_line_high: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && st.modem_control[0][umcl_pkg::MC_LOOPBACK] |=> serial_out_line[0])
    else $error("serial output not high in loopback");

  a_loop_high_one: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && st.modem_control[1][umcl_pkg::MC_LOOPBACK] |=> serial_out_line[1])
    else $error("unit one serial output not high in loopback");

  a_sout_follow_zero: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && !st.modem_control[0][umcl_pkg::MC_LOOPBACK] |=> serial_out_line[0] == $past(tx_raw_line[0]))
    else $error("serial output does not follow transmitter");

  a_sout_follow_one: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && !st.modem_control[1][umcl_pkg::MC_LOOPBACK] |=> serial_out_line[1] == $past(tx_raw_line[1]))
    else $error("unit one serial output does not follow transmitter");

  a_loop_cts_rts: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && st.modem_control[0][umcl_pkg::MC_LOOPBACK] |=> modem_status[0].cts == rts_level[0])
    else $error("loopback cts does not follow rts");

  a_loop_dsr_dtr: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && st.modem_control[0][umcl_pkg::MC_LOOPBACK] |=> modem_status[0].dsr == dtr_level[0])
    else $error("loopback dsr does not follow dtr");

  a_loop_ri_aux: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && st.modem_control[0][umcl_pkg::MC_LOOPBACK] |=> modem_status[0].ri == aux_output_one[0])
    else $error("loopback ri does not follow aux one");

  a_loop_dcd_aux: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && st.modem_control[0][umcl_pkg::MC_LOOPBACK] |=> modem_status[0].dcd == aux_output_two[0])
    else $error("loopback dcd does not follow aux two");

  a_loop_cts_one: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && st.modem_control[1][umcl_pkg::MC_LOOPBACK] |=> modem_status[1].cts == rts_level[1])
    else $error("unit one loopback cts wrong");

  a_loop_dsr_one: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && st.modem_control[1][umcl_pkg::MC_LOOPBACK] |=> modem_status[1].dsr == dtr_level[1])
    else $error("unit one loopback dsr wrong");

  a_loop_ri_one: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && st.modem_control[1][umcl_pkg::MC_LOOPBACK] |=> modem_status[1].ri == aux_output_one[1])
    else $error("unit one loopback ri wrong");

  a_loop_dcd_one: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && st.modem_control[1][umcl_pkg::MC_LOOPBACK] |=> modem_status[1].dcd == aux_output_two[1])
    else $error("unit one loopback dcd wrong");

  a_modem_pass: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && !st.modem_control[0][umcl_pkg::MC_LOOPBACK] |=> modem_status[0] == $past(modem_in[0]))
    else $error("modem status does not follow inputs");

  a_aux_two_inv: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en |=> aux_output_two[1] == !$past(st.modem_control[1][umcl_pkg::MC_AUX2]))
    else $error("aux output two not inverted");

  a_aux_two_zero: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en |=> aux_output_two[0] == !$past(st.modem_control[0][umcl_pkg::MC_AUX2]))
    else $error("unit zero aux output two not inverted");

  a_aux_one_zero: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en |=> aux_output_one[0] == !$past(st.modem_control[0][umcl_pkg::MC_AUX1]))
    else $error("aux output one not inverted");

  a_aux_one_one: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en |=> aux_output_one[1] == !$past(st.modem_control[1][umcl_pkg::MC_AUX1]))
    else $error("unit one aux output one not inverted");

  a_rts_inv_zero: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en |=> rts_level[0] == !$past(st.modem_control[0][umcl_pkg::MC_RTS]))
    else $error("rts not inverted");

  a_rts_inv_one: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en |=> rts_level[1] == !$past(st.modem_control[1][umcl_pkg::MC_RTS]))
    else $error("unit one rts not inverted");

  a_dtr_inverted: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && bus_wr && hit_mc[0] ##1 clk_en |=> dtr_level[0] == !$past(bus_wdata[0], 2))
    else $error("dtr level wrong after write");

  a_dtr_inv_one: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en |=> dtr_level[1] == !$past(st.modem_control[1][umcl_pkg::MC_DTR]))
    else $error("unit one dtr not inverted");

  a_mc_read_zero: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && bus_rd && (hit_mc[0] || hit_mc[1]) |=> bus_rdata[15:5] == 11'h000)
    else $error("modem control upper bits not zero");

  a_mc_write_zero: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && bus_wr && hit_mc[0] |=> st.modem_control[0] == $past(bus_wdata[umcl_pkg::MC_WIDTH-1:0]))
    else $error("modem control write lost");

  a_mc_write_one: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && bus_wr && hit_mc[1] |=> st.modem_control[1] == $past(bus_wdata[umcl_pkg::MC_WIDTH-1:0]))
    else $error("unit one modem control write lost");

  a_ls_read_val: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && bus_rd && hit_ls[1] |=> bus_rdata == {8'h00, $past(st.line_status[1])})
    else $error("line status read value wrong");

  a_ls_read_zero: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && bus_rd && hit_ls[0] |=> bus_rdata == {8'h00, $past(st.line_status[0])})
    else $error("unit zero line status read value wrong");

  a_unmapped_zero: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && bus_rd && !(|hit_mc) && !(|hit_ls) |=> bus_rdata == 16'h0000)
    else $error("unmapped read not zero");

  a_qerr_set: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && (evt[0].rx_parity_bad || evt[0].rx_stop_bad || evt[0].rx_break)
    |=> st.line_status[0][umcl_pkg::LS_RX_QUEUE_ERR])
    else $error("queue error flag not set");

  a_qerr_keep: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && bus_rd && hit_ls[1] && evt[1].rx_queue_err_left |=> st.line_status[1][umcl_pkg::LS_RX_QUEUE_ERR])
    else $error("queue error cleared while errors remain");

  a_tx_all_empty_flag_clear: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && evt[0].tx_hold_written |=> !st.line_status[0][umcl_pkg::LS_TX_ALL_EMPTY])
    else $error("all empty not cleared by write");

  a_tx_all_empty_flag_set: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && evt[1].tx_shift_done && !evt[1].tx_hold_written
    && (st.line_status[1][umcl_pkg::LS_TX_HOLD_EMPTY] || evt[1].tx_hold_loaded)
    |=> st.line_status[1][umcl_pkg::LS_TX_ALL_EMPTY])
    else $error("all empty not set after shift");

  a_thr_write_clr: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && evt[0].tx_hold_written |=> !st.line_status[0][umcl_pkg::LS_TX_HOLD_EMPTY])
    else $error("holding empty not cleared by write");

  a_tx_holding_empty_flag_set: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && evt[1].tx_hold_loaded && !evt[1].tx_hold_written |=> st.line_status[1][umcl_pkg::LS_TX_HOLD_EMPTY])
    else $error("holding empty not set after load");

  a_break_clear: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && bus_rd && hit_ls[0] && !evt[0].rx_break |=> !st.line_status[0][umcl_pkg::LS_BREAK])
    else $error("break flag not cleared by read");

  a_break_set: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && evt[1].rx_break |=> st.line_status[1][umcl_pkg::LS_BREAK])
    else $error("break event lost");

  a_framing_set: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && evt[1].rx_stop_bad |=> st.line_status[1][umcl_pkg::LS_FRAMING])
    else $error("framing event lost");

  a_framing_clear: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && bus_rd && hit_ls[1] && !evt[1].rx_stop_bad |=> !st.line_status[1][umcl_pkg::LS_FRAMING])
    else $error("framing flag not cleared by read");

  a_parity_keep: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && evt[0].rx_parity_bad |=> st.line_status[0][umcl_pkg::LS_PARITY])
    else $error("parity event lost");

  a_parity_clear: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && bus_rd && hit_ls[1] && !evt[1].rx_parity_bad |=> !st.line_status[1][umcl_pkg::LS_PARITY])
    else $error("parity flag not cleared by read");

  a_overrun_set: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && evt[1].rx_byte && st.line_status[1][umcl_pkg::LS_RX_READY] && !evt[1].rx_read
    |=> st.line_status[1][umcl_pkg::LS_OVERRUN])
    else $error("overrun not flagged");

  a_overrun_clear: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && bus_rd && hit_ls[1] && !evt[1].rx_byte |=> !st.line_status[1][umcl_pkg::LS_OVERRUN])
    else $error("overrun flag not cleared by read");

  a_ready_hold: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && st.line_status[0][umcl_pkg::LS_RX_READY] && !evt[0].rx_read |=> st.line_status[0][umcl_pkg::LS_RX_READY])
    else $error("data ready dropped without receive read");

  a_ready_set: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && evt[1].rx_byte |=> st.line_status[1][umcl_pkg::LS_RX_READY])
    else $error("data ready not set by new byte");

  a_ready_clear: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && evt[1].rx_read && !evt[1].rx_byte |=> !st.line_status[1][umcl_pkg::LS_RX_READY])
    else $error("data ready not cleared by receive read");

  a_break_bits: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en |=> break_char_bits[1] == umcl_pkg::CHAR_BITS_BASE + $past({2'b00, char_size_field[1]}))
    else $error("break length does not follow size code");

  a_loop_rx_feed: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && st.modem_control[0][umcl_pkg::MC_LOOPBACK] |=> rx_line[0] == $past(tx_raw_line[0]))
    else $error("loopback receiver input does not follow transmitter");

  a_collide_keep: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && bus_rd && hit_ls[1] && evt[1].rx_stop_bad |=> st.line_status[1][umcl_pkg::LS_FRAMING])
    else $error("event lost in clearing read");

  a_enable_freeze: assert property (@(posedge clk) disable iff (!arst_n)
    !clk_en |=> $stable(st))
    else $error("state moved while clock enable low");

endmodule
